// [rtl/cmt_pkg.sv]
// Package for the cycle timer unit capture block: offsets, fields, reset values, codes
package cmt_pkg;

  // Register port geometry
  localparam int unsigned CMT_AW = 4;
  localparam int unsigned CMT_DW = 16;

  // Register offsets
  localparam logic [3:0] CMT_OFF_CTRL = 4'h0;
  localparam logic [3:0] CMT_OFF_STAT = 4'h1;
  localparam logic [3:0] CMT_OFF_IER = 4'h2;
  localparam logic [3:0] CMT_OFF_CNT = 4'h3;
  localparam logic [3:0] CMT_OFF_CAP = 4'h4;
  localparam logic [3:0] CMT_OFF_MSTP = 4'h5;

  // Timer control register fields
  localparam int unsigned CMT_CTRL_RUN = 0;
  localparam int unsigned CMT_CTRL_EDGE = 1;
  localparam int unsigned CMT_CTRL_MDS = 2;
  localparam int unsigned CMT_CTRL_CKS_LO = 3;
  localparam int unsigned CMT_CTRL_AUX = 6;
  localparam logic [15:0] CMT_CTRL_RST = 16'h0000;
  localparam logic [15:0] CMT_CTRL_MASK = 16'h007F;

  // Timer status register fields, also the layout of the interrupt enable bits
  localparam int unsigned CMT_STAT_CAP = 0;
  localparam int unsigned CMT_STAT_OVF = 1;
  localparam int unsigned CMT_STAT_MODE = 2;
  localparam logic [1:0] CMT_STAT_RST = 2'h0;

  // Unit interrupt enable register fields
  localparam int unsigned CMT_IER_PIN_EN = 7;
  localparam logic [1:0] CMT_IER_RST = 2'h0;

  // Module stop register fields
  localparam int unsigned CMT_MSTP_STOP = 0;
  localparam int unsigned CMT_MSTP_KEEP = 1;
  localparam logic [1:0] CMT_MSTP_RST = 2'h1;

  // Counter values
  localparam logic [15:0] CMT_CNT_RST = 16'h0000;
  localparam logic [15:0] CMT_CNT_MAX = 16'hFFFF;

  // Count clock codes and prescaler
  localparam logic [2:0] CMT_CKS_EXT = 3'h7;
  localparam int unsigned CMT_PRE_W = 12;
  localparam logic [11:0] CMT_PRE_RST = 12'h000;

  // Effective operating mode
  typedef enum logic {
    CMT_MODE_TIMER,
    CMT_MODE_CYCLE
  } cmt_mode_t;

endpackage

// [rtl/cmt_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none

module cmt_pin_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_q, s2_q, s3_q, lvl_q;
  logic s1_d, s2_d, s3_d, lvl_d;

  // Next state: the stable level moves only when stages two and three agree
  always_comb begin
    s1_d = pin;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  // Stage registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  // One-cycle pulses on a change of the filtered level
  assign level = lvl_q;
  assign rise = lvl_d & ~lvl_q;
  assign fall = ~lvl_d & lvl_q;

endmodule // cmt_pin_sync

`default_nettype wire

// [rtl/cmt_capture.sv]
// Cycle timer unit: counter, input capture, mode control, module stop and registers
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - In timer mode a selected edge on the cycle input pin copies the cycle counter into the capture holding register.
// - The capture flag in the timer status register is set in the same cycle as that capture.
// - The edge polarity select bit picks rising or falling edges of the cycle input as the capture trigger.
// - Clearing measure mode select in cycle measurement mode together with a selected edge keeps that mode until the next selected edge.
// - After reset the module stop control holds the unit stopped, and software may let it run while stopped.
// - The unit's registers are reachable by software only once the unit is released from module stop.
// - With the cycle input pin enable bit at 1 and the auxiliary select bit clear the shared pin serves as the unit's cycle input.
module cmt_capture
  import cmt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic cycle_input_pin,
  input wire logic external_count_clock_pin,
  input wire logic aux_measure_input_pin,
  output logic cycle_input_pin_select,
  output logic irq
);

  // Prescaler tick for the chosen count clock
  function automatic logic cmt_tick(input logic [2:0] cks, input logic [11:0] pre, input logic ext_rise);
    logic t;
    t = 1'b0;
    case (cks)
      3'h0: t = 1'b1;
      3'h1: t = pre[0];
      3'h2: t = &pre[2:0];
      3'h3: t = &pre[4:0];
      3'h4: t = &pre[5:0];
      3'h5: t = &pre[7:0];
      3'h6: t = &pre[11:0];
      default: t = ext_rise;
    endcase
    return t;
  endfunction

  // Edge chosen by a polarity bit: 0 rising, 1 falling
  function automatic logic cmt_edge(input logic pol, input logic rise, input logic fall);
    return pol ? fall : rise;
  endfunction

  // Register state
  logic [15:0] ctrl_q, ctrl_d;
  logic [1:0] stat_q, stat_d;
  logic [1:0] ie_q, ie_d;
  logic pin_en_q, pin_en_d;
  logic [1:0] mstp_q, mstp_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cap_q, cap_d;
  logic [11:0] pre_q, pre_d;
  logic [15:0] rdata_q, rdata_d;
  cmt_mode_t mode_q, mode_d;
  logic hold_q, hold_d;

  // Synchronised pin edges; the filtered levels themselves are not needed here
  logic cyc_rise, cyc_fall;
  logic ext_rise;
  logic aux_rise, aux_fall;

  // Decoded access and events
  logic acc_ok;
  logic wr_ctrl, wr_stat, wr_ier, wr_cnt, wr_mstp;
  logic unit_on;
  logic run;
  logic tick;
  logic src_rise, src_fall;
  logic sel_edge;
  logic cap_evt;
  logic ovf_evt;
  logic mds_clr_wr;

  // Pin synchronisers for the cycle input, external clock and auxiliary input
  cmt_pin_sync u_sync_cyc (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(cycle_input_pin),
    .level(),
    .rise(cyc_rise),
    .fall(cyc_fall)
  );

  cmt_pin_sync u_sync_ext (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(external_count_clock_pin),
    .level(),
    .rise(ext_rise),
    .fall()
  );

  cmt_pin_sync u_sync_aux (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(aux_measure_input_pin),
    .level(),
    .rise(aux_rise),
    .fall(aux_fall)
  );

  // Unit runs unless module-stopped without the keep-running option
  assign unit_on = ~mstp_q[CMT_MSTP_STOP] | mstp_q[CMT_MSTP_KEEP];
  assign acc_ok = ~mstp_q[CMT_MSTP_STOP];

  // Write strobes per register; unit registers are blocked while stopped
  always_comb begin
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_ier = 1'b0;
    wr_cnt = 1'b0;
    wr_mstp = 1'b0;
    if (reg_wr && reg_addr == CMT_OFF_MSTP) begin
      wr_mstp = 1'b1;
    end else if (reg_wr && acc_ok && reg_addr == CMT_OFF_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr && acc_ok && reg_addr == CMT_OFF_STAT) begin
      wr_stat = 1'b1;
    end else if (reg_wr && acc_ok && reg_addr == CMT_OFF_IER) begin
      wr_ier = 1'b1;
    end else if (reg_wr && acc_ok && reg_addr == CMT_OFF_CNT) begin
      wr_cnt = 1'b1;
    end
  end

  // Capture source: the enabled cycle pin or the auxiliary input
  always_comb begin
    if (ctrl_q[CMT_CTRL_AUX]) begin
      src_rise = aux_rise;
      src_fall = aux_fall;
    end else begin
      src_rise = cyc_rise & pin_en_q;
      src_fall = cyc_fall & pin_en_q;
    end
  end

  // Selected edge, count tick and events
  assign sel_edge = unit_on & cmt_edge(ctrl_q[CMT_CTRL_EDGE], src_rise, src_fall);
  assign run = unit_on & ctrl_q[CMT_CTRL_RUN];
  // With the external clock code the tick is a rising edge of the external clock pin only, never the auxiliary pin
  assign tick = run & cmt_tick(ctrl_q[CMT_CTRL_CKS_LO +: 3], pre_q, ext_rise);
  assign cap_evt = sel_edge;
  assign ovf_evt = tick & (cnt_q == CMT_CNT_MAX) & ~(cap_evt && mode_q == CMT_MODE_CYCLE);
  assign mds_clr_wr = wr_ctrl & ctrl_q[CMT_CTRL_MDS] & ~reg_wdata[CMT_CTRL_MDS];

  // Control, status, enable and module stop registers
  always_comb begin
    ctrl_d = ctrl_q;
    stat_d = stat_q;
    ie_d = ie_q;
    pin_en_d = pin_en_q;
    mstp_d = mstp_q;
    if (wr_ctrl) begin
      ctrl_d = reg_wdata & CMT_CTRL_MASK;
    end
    if (wr_ier) begin
      ie_d = reg_wdata[CMT_STAT_OVF:CMT_STAT_CAP];
      pin_en_d = reg_wdata[CMT_IER_PIN_EN];
    end
    if (wr_mstp) begin
      mstp_d = reg_wdata[CMT_MSTP_KEEP:CMT_MSTP_STOP];
    end
    // Write one to clear, then events set; the set wins
    if (wr_stat) begin
      stat_d = stat_q & ~reg_wdata[CMT_STAT_OVF:CMT_STAT_CAP];
    end
    if (cap_evt) begin
      stat_d[CMT_STAT_CAP] = 1'b1;
    end
    if (ovf_evt) begin
      stat_d[CMT_STAT_OVF] = 1'b1;
    end
  end

  // Register storage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CMT_CTRL_RST;
      stat_q <= CMT_STAT_RST;
      ie_q <= CMT_IER_RST;
      pin_en_q <= 1'b0;
      mstp_q <= CMT_MSTP_RST;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      ie_q <= ie_d;
      pin_en_q <= pin_en_d;
      mstp_q <= mstp_d;
    end
  end

  // Effective mode; a mode-select clear that meets an edge is held off
  always_comb begin
    mode_d = mode_q;
    hold_d = hold_q;
    case (mode_q)
      CMT_MODE_CYCLE: begin
        if (hold_q) begin
          if (ctrl_q[CMT_CTRL_MDS]) begin
            hold_d = 1'b0;
          end else if (sel_edge) begin
            mode_d = CMT_MODE_TIMER;
            hold_d = 1'b0;
          end
        end else if (mds_clr_wr && sel_edge) begin
          hold_d = 1'b1;
        end else if (!ctrl_q[CMT_CTRL_MDS]) begin
          mode_d = CMT_MODE_TIMER;
        end
      end
      default: begin
        if (ctrl_q[CMT_CTRL_MDS]) begin
          mode_d = CMT_MODE_CYCLE;
        end
      end
    endcase
  end

  // Mode storage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= CMT_MODE_TIMER;
      hold_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      hold_q <= hold_d;
    end
  end

  // Prescaler, counter and capture holding register
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    cap_d = cap_q;
    if (run) begin
      pre_d = pre_q + 12'h001;
    end
    if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
    if (cap_evt) begin
      cap_d = cnt_q;
      if (mode_q == CMT_MODE_CYCLE) begin
        cnt_d = CMT_CNT_RST;
      end
    end
    if (wr_cnt) begin
      cnt_d = reg_wdata;
    end
  end

  // Counter storage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= CMT_PRE_RST;
      cnt_q <= CMT_CNT_RST;
      cap_q <= CMT_CNT_RST;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      cap_q <= cap_d;
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd && reg_addr == CMT_OFF_MSTP) begin
      rdata_d = {14'h0000, mstp_q};
    end else if (reg_rd && !acc_ok) begin
      rdata_d = 16'h0000;
    end else if (reg_rd && reg_addr == CMT_OFF_CTRL) begin
      rdata_d = ctrl_q;
    end else if (reg_rd && reg_addr == CMT_OFF_STAT) begin
      rdata_d = {13'h0000, mode_q == CMT_MODE_CYCLE, stat_q};
    end else if (reg_rd && reg_addr == CMT_OFF_IER) begin
      rdata_d = {8'h00, pin_en_q, 5'h00, ie_q};
    end else if (reg_rd && reg_addr == CMT_OFF_CNT) begin
      rdata_d = cnt_q;
    end else if (reg_rd && reg_addr == CMT_OFF_CAP) begin
      rdata_d = cap_q;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign cycle_input_pin_select = pin_en_q;
  assign irq = |(stat_q & ie_q);

endmodule // cmt_capture

`default_nettype wire

// [verif/cmt_capture_assertions.sv]
// Port checker for the cycle timer capture block
`timescale 1ns/10ps
`default_nettype none

module cmt_capture_assertions
  import cmt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic cycle_input_pin,
  input wire logic external_count_clock_pin,
  input wire logic aux_measure_input_pin,
  input wire logic cycle_input_pin_select,
  input wire logic irq
);
  logic [1:0] ms_q, ms_d;
  logic mw, iw;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Shadow of the stop and keep bits
  assign mw = reg_wr && reg_addr == CMT_OFF_MSTP;
  assign iw = reg_wr && reg_addr == CMT_OFF_IER;
  always_comb ms_d = mw ? reg_wdata[1:0] : ms_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) ms_q <= 2'h1;
    else ms_q <= ms_d;
  end
  property p_sel_wr;
    iw && !ms_q[0] |=> cycle_input_pin_select == $past(reg_wdata[7]);
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("pin select not loaded");
  property p_sel_hold;
    !(iw && !ms_q[0]) |=> $stable(cycle_input_pin_select);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("pin select moved");
  property p_mstp_rd;
    reg_rd && reg_addr == CMT_OFF_MSTP |=> reg_rdata[0] == ms_q[0];
  endproperty
  a_mstp_rd: assert property (p_mstp_rd) else $error("stop bit read wrong");
  property p_stop_rd;
    reg_rd && ms_q[0] && reg_addr != CMT_OFF_MSTP |=> reg_rdata == 16'h0000;
  endproperty
  a_stop_rd: assert property (p_stop_rd) else $error("read while stopped");
  property p_rd_zero;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data without read");
  property p_unmapped;
    reg_rd && reg_addr > CMT_OFF_MSTP |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_fall;
    $fell(irq) |-> $past(reg_wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  property p_irq_stop;
    $rose(irq) |-> !$past(ms_q[0]) || $past(ms_q[1]) || $past(reg_wr);
  endproperty
  a_irq_stop: assert property (p_irq_stop) else $error("irq while stopped");
endmodule // cmt_capture_assertions

bind cmt_capture cmt_capture_assertions i_cmt_capture_assertions (.sys_clk(sys_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cycle_input_pin(cycle_input_pin), .external_count_clock_pin(external_count_clock_pin),
  .aux_measure_input_pin(aux_measure_input_pin), .cycle_input_pin_select(cycle_input_pin_select), .irq(irq));

`default_nettype wire

// [verif/cmt_pulse_src.sv]
// Pulse source model for the cycle input and external clock pins
`timescale 1ns/10ps
`default_nettype none

module cmt_pulse_src (
  input wire logic sys_clk,
  output logic cyc_pin,
  output logic clk_pin
);
  initial cyc_pin = 1'b0;
  initial clk_pin = 1'b0;
  // Moves the cycle input after gap cycles, prompt or slow
  task automatic cyc(input logic v, input int gap);
    repeat (gap) @(posedge sys_clk);
    cyc_pin <= v;
  endtask
  // Gives n clock pulses, each level held three cycles
  task automatic clk(input int n);
    repeat (n) begin
      clk_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      clk_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule // cmt_pulse_src

`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the cycle timer capture block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import cmt_pkg::*;
  logic sys_clk, rst_b, reg_wr, reg_rd, aux_pin;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, v, cap;
  logic sel, irq;
  wire cyc_pin, ext_pin;
  int errors, n_tests, n;
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  cmt_capture i_cmt_capture (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_input_pin(cyc_pin),
    .external_count_clock_pin(ext_pin), .aux_measure_input_pin(aux_pin), .cycle_input_pin_select(sel), .irq(irq));
  cmt_pulse_src i_cmt_pulse_src (.sys_clk(sys_clk), .cyc_pin(cyc_pin), .clk_pin(ext_pin));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic complete_run;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    wait_n(20000);
    errors++;
    complete_run;
  end
  // Main sequence
  initial begin
    void'($urandom(32'h68950646));
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    aux_pin = 1'b0;
    errors = 0;
    n_tests = 0;
    cap = 16'h0000;
    wait_n(12);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk("pin_sel_rst", {15'h0000, sel}, 16'h0000);
    // Stopped after reset, only the stop register answers
    rd(CMT_OFF_MSTP, d);
    chk("mstp", d, 16'h0001);
    wr(CMT_OFF_IER, 16'h0081);
    rd(CMT_OFF_IER, d);
    chk("ier_stopped", d, 16'h0000);
    wr(CMT_OFF_MSTP, 16'h0000);
    rd(4'hA, d);
    chk("unmapped", d, 16'h0000);
    // Both polarities, pin enabled and then disabled; counter frozen
    for (int i = 0; i < 4; i++) begin
      wr(CMT_OFF_IER, {8'h00, !i[1], 6'h00, 1'b1});
      chk("pin_sel", {15'h0000, sel}, {15'h0000, !i[1]});
      wr(CMT_OFF_CTRL, {14'h0000, i[0], 1'b0});
      v = 16'($urandom);
      wr(CMT_OFF_CNT, v);
      i_cmt_pulse_src.cyc(i[0], 0);
      wait_n(6);
      wr(CMT_OFF_STAT, 16'h0003);
      i_cmt_pulse_src.cyc(!i[0], i);
      wait_n(6);
      if (!i[1]) cap = v;
      rd(CMT_OFF_STAT, d);
      chk("flag_set", d, {15'h0000, !i[1]});
      rd(CMT_OFF_CAP, d);
      chk("capture", d, cap);
      chk("irq_set", {15'h0000, irq}, {15'h0000, !i[1]});
      wr(CMT_OFF_STAT, 16'h0003);
      i_cmt_pulse_src.cyc(i[0], 0);
      wait_n(6);
      rd(CMT_OFF_STAT, d);
      chk("flag_other_edge", d, 16'h0000);
    end
    // Counting every cycle: two reads a known span apart
    wr(CMT_OFF_CTRL, 16'h0001);
    n = $urandom_range(9, 1);
    rd(CMT_OFF_CNT, v);
    wait_n(n);
    rd(CMT_OFF_CNT, d);
    chk("cnt_step", d - v, 16'(n + 2));
    // External clock code with aux select left clear
    wr(CMT_OFF_CTRL, 16'h0000);
    v = 16'($urandom);
    wr(CMT_OFF_CNT, v);
    wr(CMT_OFF_CTRL, 16'h0039);
    n = $urandom_range(6, 1);
    i_cmt_pulse_src.clk(n);
    wait_n(4);
    rd(CMT_OFF_CNT, d);
    chk("cnt_ext", d - v, 16'(n));
    // Mode clear landing on a selected edge
    i_cmt_pulse_src.cyc(1'b0, 0);
    wr(CMT_OFF_IER, 16'h0081);
    wr(CMT_OFF_CTRL, 16'h0005);
    wait_n(4);
    i_cmt_pulse_src.cyc(1'b1, 0);
    wait_n(3);
    wr(CMT_OFF_CTRL, 16'h0001);
    rd(CMT_OFF_STAT, d);
    chk("mode_hold", d & 16'h0005, 16'h0005);
    wr(CMT_OFF_IER, 16'h0080);
    chk("irq_mask", {15'h0000, irq}, 16'h0000);
    wr(CMT_OFF_STAT, 16'h0001);
    wr(CMT_OFF_IER, 16'h0081);
    chk("irq_clear", {15'h0000, irq}, 16'h0000);
    i_cmt_pulse_src.cyc(1'b0, 0);
    wait_n(6);
    rd(CMT_OFF_STAT, d);
    chk("mode_keep", d & 16'h0004, 16'h0004);
    i_cmt_pulse_src.cyc(1'b1, 0);
    wait_n(6);
    rd(CMT_OFF_STAT, d);
    chk("mode_left", d & 16'h0004, 16'h0000);
    // Overflow from the top count, then capture from the auxiliary input
    wr(CMT_OFF_STAT, 16'h0003);
    wr(CMT_OFF_CNT, 16'hFFFE);
    wr(CMT_OFF_CTRL, 16'h0001);
    wait_n(4);
    wr(CMT_OFF_CTRL, 16'h0000);
    rd(CMT_OFF_STAT, d);
    chk("ovf_flag", d & 16'h0002, 16'h0002);
    v = 16'($urandom);
    wr(CMT_OFF_CNT, v);
    wr(CMT_OFF_CTRL, 16'h0040);
    aux_pin <= 1'b1;
    wait_n(6);
    rd(CMT_OFF_CAP, d);
    chk("aux_capture", d, v);
    // Leaving cycle measurement mode the safe way: run bit cleared first
    wr(CMT_OFF_CTRL, 16'h0005);
    wr(CMT_OFF_CTRL, 16'h0004);
    wr(CMT_OFF_CTRL, 16'h0000);
    rd(CMT_OFF_STAT, d);
    chk("mode_exit", d & 16'h0004, 16'h0000);
    complete_run;
  end
endmodule // tb_top

`default_nettype wire
